/* sage_map.vh */
`ifndef SAGE_MAP_VH
`define SAGE_MAP_VH

// Register byte offsets within the block.
`define SAGE_OFS_CORR_EN      12'h038
`define SAGE_OFS_UPD_EN       12'h078
`define SAGE_OFS_CNT0         12'h0f0
`define SAGE_OFS_CNT1         12'h0f4
`define SAGE_OFS_ADR0         12'h10c
`define SAGE_OFS_ADR1         12'h110
`define SAGE_OFS_DMA_PERMIT   12'h12c
`define SAGE_OFS_CTRL_PERMIT  12'h130
`define SAGE_OFS_FLAGS        12'h190
`define SAGE_OFS_CNT_CLR      12'h1a4

// Field layout and reset values.
`define SAGE_PERMIT_W         10
`define SAGE_PERMIT_RST       10'h3ff
`define SAGE_FLAG_W           4
`define SAGE_FLAG_RST         4'h0
`define SAGE_CORR_W           2
`define SAGE_CORR_RST         2'h0
`define SAGE_CNT_W            16
`define SAGE_ADR_W            13
`define SAGE_ADR_SINGLE_LSB   0
`define SAGE_ADR_DOUBLE_LSB   13

// Slave numbers guarded by the permit registers.
`define SAGE_SLV_SRAM0        3'h0
`define SAGE_SLV_SRAM1        3'h1
`define SAGE_SLV_NVM0         3'h2
`define SAGE_SLV_NVM1         3'h3
`define SAGE_SLV_DDR          3'h6

// Master numbers seen by the access check.
`define SAGE_MST_DMA_A        4'h3
`define SAGE_MST_DMA_B        4'h7
`define SAGE_MST_CTRL         4'h9

`endif

/* sage_regs.v */
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sage_map.vh"

module sage_regs #(
  parameter ADDR_W = 12
) (
  input  wire                        clk_i,
  input  wire                        rst_i,
  input  wire                        wb_cyc_i,
  input  wire                        wb_stb_i,
  input  wire                        wb_we_i,
  input  wire [ADDR_W-1:0]           wb_adr_i,
  input  wire [3:0]                  wb_sel_i,
  input  wire [31:0]                 wb_dat_i,
  output reg  [31:0]                 wb_dat_o,
  output reg                         wb_ack_o,
  output reg                         wb_err_o,
  input  wire                        cfg_load_i,
  input  wire [`SAGE_PERMIT_W-1:0]   cfg_dma_permits_i,
  input  wire [`SAGE_PERMIT_W-1:0]   cfg_ctrl_permits_i,
  input  wire                        chk_valid_i,
  input  wire [3:0]                  chk_master_i,
  input  wire [2:0]                  chk_slave_i,
  input  wire                        chk_write_i,
  output reg                         chk_done_o,
  output reg                         chk_err_o,
  input  wire [1:0]                  sram_single_err_i,
  input  wire [1:0]                  sram_double_err_i,
  input  wire [2*`SAGE_ADR_W-1:0]    sram_err_addr_i,
  output reg  [`SAGE_CORR_W-1:0]     sram_correct_enable_o,
  output reg  [3:0]                  count_clear_o,
  output reg  [`SAGE_PERMIT_W-1:0]   dma_port_access_permits_o,
  output reg  [`SAGE_PERMIT_W-1:0]   controller_access_permits_o
);

  // This block is the guard and error book-keeping register group that
  // sits between software, the bus matrix and the two SRAM controllers.
  // Software reaches it over a classic Wishbone slave port with a fixed
  // single wait state.
  // The permit levels are loaded by the configuration path only and are
  // read-only to software, so a stray bus write cannot open a slave.
  // The error side keeps sticky flags, saturating counts and the word
  // address of the latest error of each kind for both SRAMs.
  // All state is reset synchronously and every output is registered, so
  // the consumers never see a combinational glitch from the bus decode.
  // Nothing here stalls the bus matrix: the access verdict always comes
  // exactly one cycle after the check request.

  // Software visible state.
  reg [`SAGE_FLAG_W-1:0]  sram_error_flags_r;
  reg [`SAGE_FLAG_W-1:0]  error_flag_update_enable_r;
  reg [`SAGE_CNT_W-1:0]   single_cnt_r [0:1];
  reg [`SAGE_CNT_W-1:0]   double_cnt_r [0:1];
  reg [`SAGE_ADR_W-1:0]   single_adr_r [0:1];
  reg [`SAGE_ADR_W-1:0]   double_adr_r [0:1];

  // Bus decode helpers.
  wire        req;
  wire        wr_fire;
  wire [31:0] wmask;
  wire [31:0] wbits;
  reg         hit;
  reg  [31:0] rdata;

  // Error events that are allowed to reach flags and counters.
  wire [3:0]  err_ev;
  wire [3:0]  flag_set;
  wire [3:0]  flag_clr;
  reg  [31:0] clr_word;
  reg         permit;
  reg  [3:0]  pidx;
  reg  [`SAGE_PERMIT_W-1:0] pvec;

  // A request is taken only while no answer is showing.
  // Masking with the answer keeps a strobe that is still high in the ack
  // cycle from being taken a second time.
  // The master has to drop cyc and stb for a cycle after the answer; a
  // strobe held high would be seen as a fresh request after the drop.
  // Byte enables mask the write data, so a partial write treats the
  // other bytes of a field as zero instead of leaving them untouched.
  // For the flag register a zero is a no-op, which is what the mask gives.
  // For the control registers a masked byte writes zero into its bits.
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wbits = wb_dat_i & wmask;
  // A write lands on the edge where the master sees ack.
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // Error events come straight from the SRAM controllers as one cycle
  // pulses, one pulse per detected error.
  // They are taken as synchronous to clk_i; no resynchronisation is done.
  // An event seen while correction is off for that SRAM is dropped here,
  // before it reaches the counts, the addresses or the flags.
  // The flags need the update enable as well, while the counts and the
  // captured addresses only need correction to be on.
  // That lets software silence the flags and still watch the counts grow.
  // Events only count while correction is on for that SRAM.
  assign err_ev = {sram_double_err_i[1] & sram_correct_enable_o[1],
                   sram_single_err_i[1] & sram_correct_enable_o[1],
                   sram_double_err_i[0] & sram_correct_enable_o[0],
                   sram_single_err_i[0] & sram_correct_enable_o[0]};
  // Flags also need their update enable.
  assign flag_set = err_ev & error_flag_update_enable_r;

  // Clear request from a write of ones to the flag register.
  always @* begin
    clr_word = 32'h0000_0000;
    if (wr_fire && wb_adr_i == `SAGE_OFS_FLAGS) begin
      clr_word = wbits;
    end
  end
  assign flag_clr = clr_word[`SAGE_FLAG_W-1:0];

  // The decode compares the full byte address, so any offset that is not
  // listed below answers with err and has no effect at all.
  // Unused bits of every register read back as zero.
  // The counter clear register is write-only and always reads zero, since
  // its strobes last one cycle and there is nothing left to show.
  // The count and address registers are read-only; a write to them is
  // acknowledged and ignored, so software sees no bus error for it.
  // Address decode and read multiplexer.
  always @* begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      `SAGE_OFS_CORR_EN:
        rdata = {30'h0, sram_correct_enable_o};
      `SAGE_OFS_UPD_EN:
        rdata = {28'h0, error_flag_update_enable_r};
      `SAGE_OFS_CNT0:
        rdata = {double_cnt_r[0], single_cnt_r[0]};
      `SAGE_OFS_CNT1:
        rdata = {double_cnt_r[1], single_cnt_r[1]};
      `SAGE_OFS_ADR0:
        rdata = {6'h0, double_adr_r[0], single_adr_r[0]};
      `SAGE_OFS_ADR1:
        rdata = {6'h0, double_adr_r[1], single_adr_r[1]};
      `SAGE_OFS_DMA_PERMIT:
        rdata = {22'h0, dma_port_access_permits_o};
      `SAGE_OFS_CTRL_PERMIT:
        rdata = {22'h0, controller_access_permits_o};
      `SAGE_OFS_FLAGS:
        rdata = {28'h0, sram_error_flags_r};
      `SAGE_OFS_CNT_CLR:
        rdata = 32'h0000_0000;
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Wishbone answer: ack or err one cycle after the request.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      if (req & hit & ~wb_we_i) begin
        wb_dat_o <= rdata;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Both control registers reset to zero, so correction and flag updates
  // are off until software turns them on after the SRAMs are set up.
  // A write lands only on the edge where the master samples ack high,
  // which is the one edge at which the request is sure to be stable.
  // Bits above each field are dropped on write and read back as zero.
  // Control registers written by software.
  always @(posedge clk_i) begin
    if (rst_i) begin
      sram_correct_enable_o      <= `SAGE_CORR_RST;
      error_flag_update_enable_r <= `SAGE_FLAG_RST;
    end else if (wr_fire) begin
      if (wb_adr_i == `SAGE_OFS_CORR_EN) begin
        sram_correct_enable_o <= wbits[`SAGE_CORR_W-1:0];
      end
      if (wb_adr_i == `SAGE_OFS_UPD_EN) begin
        error_flag_update_enable_r <=
          wbits[`SAGE_FLAG_W-1:0];
      end
    end
  end

  // The permit levels reset to all ones, so every guarded access is
  // allowed until the configuration path says otherwise.
  // A load takes both registers in the same edge, so the bus matrix never
  // sees a mix of an old and a new permit set between the two masters.
  // Holding cfg_load_i high keeps following the configuration inputs.
  // The bus cannot change these registers; that path only reads them.
  // Permit registers: read only to software, loaded by configuration.
  always @(posedge clk_i) begin
    if (rst_i) begin
      dma_port_access_permits_o   <= `SAGE_PERMIT_RST;
      controller_access_permits_o <= `SAGE_PERMIT_RST;
    end else if (cfg_load_i) begin
      dma_port_access_permits_o   <= cfg_dma_permits_i;
      controller_access_permits_o <= cfg_ctrl_permits_i;
    end
  end

  // Flags are cleared by writing ones; writing zeros leaves them alone,
  // so software can clear one flag without a read-modify-write.
  // An event that arrives in the same edge as the clear sets the flag
  // again, so no error is ever lost between a read and its clear.
  // Sticky flags; a new event beats a clear in the same cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      sram_error_flags_r <= `SAGE_FLAG_RST;
    end else begin
      sram_error_flags_r <= (sram_error_flags_r & ~flag_clr)
                            | flag_set;
    end
  end

  // Each written one gives a strobe of exactly one cycle, in the cycle
  // after the write edge; a held bus request cannot stretch it.
  // The strobes are also used inside this block to zero the counts, so
  // the count reads zero one cycle after the strobe.
  // Counter clear strobes, one cycle per written one.
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_clear_o <= 4'h0;
    end else if (wr_fire && wb_adr_i == `SAGE_OFS_CNT_CLR) begin
      count_clear_o <= wbits[3:0];
    end else begin
      count_clear_o <= 4'h0;
    end
  end

  // The two SRAMs share one layout: bit 2*g of the event and strobe
  // vectors is the single-bit side of SRAM g, and bit 2*g+1 the double.
  // Counts stop at all ones so that a flood of errors can never wrap
  // around and look like a healthy memory.
  // A clear strobe beats an event in the same edge; that event is lost,
  // which is the price of a clear that always leaves a zero behind.
  // Per SRAM counters and captured error addresses.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sram
      wire s_ev;
      wire d_ev;
      wire s_clr;
      wire d_clr;
      assign s_ev  = err_ev[2*g];
      assign d_ev  = err_ev[2*g+1];
      assign s_clr = count_clear_o[2*g];
      assign d_clr = count_clear_o[2*g+1];

      // Counts hold at all ones; a clear strobe wins over an event.
      always @(posedge clk_i) begin
        if (rst_i) begin
          single_cnt_r[g] <= 16'h0000;
          double_cnt_r[g] <= 16'h0000;
        end else begin
          if (s_clr) begin
            single_cnt_r[g] <= 16'h0000;
          end else if (s_ev && single_cnt_r[g] != 16'hffff) begin
            single_cnt_r[g] <= single_cnt_r[g] + 16'h0001;
          end
          if (d_clr) begin
            double_cnt_r[g] <= 16'h0000;
          end else if (d_ev && double_cnt_r[g] != 16'hffff) begin
            double_cnt_r[g] <= double_cnt_r[g] + 16'h0001;
          end
        end
      end

      // Most recent failing word address of each kind.
      always @(posedge clk_i) begin
        if (rst_i) begin
          single_adr_r[g] <= 13'h0000;
          double_adr_r[g] <= 13'h0000;
        end else begin
          if (s_ev) begin
            single_adr_r[g] <=
              sram_err_addr_i[g*`SAGE_ADR_W +: `SAGE_ADR_W];
          end
          if (d_ev) begin
            double_adr_r[g] <=
              sram_err_addr_i[g*`SAGE_ADR_W +: `SAGE_ADR_W];
          end
        end
      end
    end
  endgenerate

  // The lookup is purely combinational and is registered below.
  // Masters 3 and 7 share one permit set, master 9 has its own, and any
  // other master is not guarded here and is always allowed.
  // Slaves outside the guarded five are always allowed as well.
  // Each guarded slave owns a pair of bits: read at the even bit and
  // write at the odd bit just above it.
  // A cleared bit makes the bus matrix end the access with an error.
  // Permit lookup for one bus matrix access.
  always @* begin
    pidx   = 4'h0;
    pvec   = {`SAGE_PERMIT_W{1'b0}};
    permit = 1'b0;
    case (chk_master_i)
      `SAGE_MST_DMA_A, `SAGE_MST_DMA_B: begin
        pvec = dma_port_access_permits_o;
      end
      `SAGE_MST_CTRL: begin
        pvec = controller_access_permits_o;
      end
      default: begin
        pvec = {`SAGE_PERMIT_W{1'b1}};
      end
    endcase
    case (chk_slave_i)
      `SAGE_SLV_SRAM0: pidx = 4'h0;
      `SAGE_SLV_SRAM1: pidx = 4'h2;
      `SAGE_SLV_NVM0:  pidx = 4'h4;
      `SAGE_SLV_NVM1:  pidx = 4'h6;
      `SAGE_SLV_DDR:   pidx = 4'h8;
      default:         pidx = 4'hf;
    endcase
    if (pidx == 4'hf) begin
      permit = 1'b1;
    end else begin
      // Read permit at even bit, write permit one above.
      permit = pvec[pidx + {3'h0, chk_write_i}];
    end
  end

  // Back to back requests are allowed; each one gets its own verdict.
  // The error flag is only meaningful while done is high.
  // Verdict registered one cycle after the check request.
  always @(posedge clk_i) begin
    if (rst_i) begin
      chk_done_o <= 1'b0;
      chk_err_o  <= 1'b0;
    end else begin
      chk_done_o <= chk_valid_i;
      chk_err_o  <= chk_valid_i & ~permit;
    end
  end

endmodule // sage_regs

/* sage_props.sv */
`timescale 1ns/1ps
`include "sage_map.vh"
module sage_props #(
  parameter ADDR_W = 12
) (
  input logic              clk_i,
  input logic              rst_i,
  input logic              wb_cyc_i,
  input logic              wb_stb_i,
  input logic              wb_we_i,
  input logic [ADDR_W-1:0] wb_adr_i,
  input logic [31:0]       wb_dat_i,
  input logic [31:0]       wb_dat_o,
  input logic              wb_ack_o,
  input logic              wb_err_o,
  input logic              cfg_load_i,
  input logic [9:0]        cfg_dma_permits_i,
  input logic [9:0]        cfg_ctrl_permits_i,
  input logic              chk_valid_i,
  input logic [3:0]        chk_master_i,
  input logic [2:0]        chk_slave_i,
  input logic              chk_write_i,
  input logic              chk_done_o,
  input logic              chk_err_o,
  input logic [3:0]        count_clear_o,
  input logic [9:0]        dma_port_access_permits_o,
  input logic [9:0]        controller_access_permits_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Expected refusal of the access check from the permit levels.
  wire       ctrl  = chk_master_i == `SAGE_MST_CTRL;
  wire [9:0] pm    = ctrl ? controller_access_permits_o
                          : dma_port_access_permits_o;
  wire [3:0] idx   = {(chk_slave_i == 3'h6 ? 3'h4 : chk_slave_i), chk_write_i};
  wire       mst   = ctrl || chk_master_i == 4'h3 || chk_master_i == 4'h7;
  wire       deny  = mst && (chk_slave_i <= 3'h3 || chk_slave_i == 3'h6)
                     && !pm[idx];
  wire       clr_w = wb_ack_o && wb_we_i && wb_adr_i == `SAGE_OFS_CNT_CLR;
  bus_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
    else $error("bus request not answered");
  ack_single_a: assert property ((wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o)
    else $error("bus answer longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  clr_pulse_a: assert property (
    clr_w |=> count_clear_o == $past(wb_dat_i[3:0]))
    else $error("counter clear pulse wrong");
  clr_cause_a: assert property (count_clear_o != 4'h0 |-> $past(clr_w))
    else $error("counter clear without write");
  chk_answer_a: assert property (
    chk_valid_i |=> chk_done_o && chk_err_o == $past(deny))
    else $error("access check answer wrong");
  chk_idle_a: assert property (!chk_valid_i |=> !chk_done_o)
    else $error("access check done without request");
  permit_load_a: assert property (
    cfg_load_i |=> dma_port_access_permits_o == $past(cfg_dma_permits_i)
    && controller_access_permits_o == $past(cfg_ctrl_permits_i))
    else $error("permit load wrong");
  permit_hold_a: assert property (!cfg_load_i |=>
    $stable(dma_port_access_permits_o) && $stable(controller_access_permits_o))
    else $error("permit changed without load");
  cover property (wb_err_o);
  cover property (chk_done_o && chk_err_o);
  cover property (count_clear_o[3]);
endmodule // sage_props
bind sage_regs sage_props #(.ADDR_W(ADDR_W)) u_props (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .wb_err_o, .cfg_load_i, .cfg_dma_permits_i, .cfg_ctrl_permits_i,
  .chk_valid_i, .chk_master_i, .chk_slave_i, .chk_write_i, .chk_done_o,
  .chk_err_o, .count_clear_o, .dma_port_access_permits_o,
  .controller_access_permits_o);

/* sage_sram_model.sv */
`timescale 1ns/1ps
module sage_sram_model (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        go_i,
  input  logic [3:0]  kind_i,
  input  logic [31:0] burst_i,
  input  logic [25:0] addr_i,
  output logic [1:0]  single_o,
  output logic [1:0]  double_o,
  output logic [25:0] addr_o,
  output logic        busy_o
);
  logic [31:0] left_r;
  // Counts the error events still to be reported, one per cycle.
  always @(posedge clk_i) begin
    if (rst_i) left_r <= 32'h0;
    else if (go_i) left_r <= burst_i;
    else if (left_r != 32'h0) left_r <= left_r - 32'h1;
  end
  // Address is only valid with an event; otherwise it shows garbage.
  assign single_o = (left_r != 32'h0) ? {kind_i[2], kind_i[0]} : 2'h0;
  assign double_o = (left_r != 32'h0) ? {kind_i[3], kind_i[1]} : 2'h0;
  assign addr_o   = (left_r != 32'h0) ? addr_i : ~addr_i;
  assign busy_o   = go_i || left_r != 32'h0;
endmodule // sage_sram_model

/* sage_tb.sv */
`timescale 1ns/1ps
`include "sage_map.vh"
module testbench;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0]  wb_sel_i = 4'hf, chk_master_i = 0, kind = 0, count_clear_o;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd, burst = 0;
  logic        wb_ack_o, wb_err_o, chk_done_o, chk_err_o, busy, e, go = 0;
  logic        cfg_load_i = 0, chk_valid_i = 0, chk_write_i = 0;
  logic [9:0]  cfg_dma_permits_i = 0, cfg_ctrl_permits_i = 0, p;
  logic [9:0]  dma_port_access_permits_o, controller_access_permits_o;
  logic [2:0]  chk_slave_i = 0;
  logic [1:0]  sram_single_err_i, sram_double_err_i, sram_correct_enable_o;
  logic [25:0] sram_err_addr_i, ea = {13'h0abc, 13'h1234};
  int          miscompares = 0, checked = 0, ms[3] = '{3, 7, 9};
  int          ss[5] = '{0, 1, 2, 3, 6};
  sage_regs i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cfg_load_i,
    .cfg_dma_permits_i, .cfg_ctrl_permits_i, .chk_valid_i, .chk_master_i,
    .chk_slave_i, .chk_write_i, .chk_done_o, .chk_err_o, .sram_single_err_i,
    .sram_double_err_i, .sram_err_addr_i, .sram_correct_enable_o,
    .count_clear_o, .dma_port_access_permits_o, .controller_access_permits_o);
  sage_sram_model i_sram (.clk_i, .rst_i, .go_i(go), .kind_i(kind),
    .burst_i(burst), .addr_i(ea), .single_o(sram_single_err_i),
    .double_o(sram_double_err_i), .addr_o(sram_err_addr_i), .busy_o(busy));
  // Free-running clock and run limit.
  initial forever #4 clk_i = ~clk_i;
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    report_and_stop;
  end
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; holds the request until ack or err is sampled.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1 && wb_err_o !== 1 && n < 20);
    if (n == 20) begin
      miscompares++;
      report_and_stop;
    end
    rd = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(0, a, 0);
    cmp(rd, exp);
  endtask
  task automatic fire(input logic [3:0] k, input logic [31:0] n);
    kind <= k;
    burst <= n;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    do @(posedge clk_i); while (busy);
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rdc(`SAGE_OFS_DMA_PERMIT, 32'h3ff);
    rdc(`SAGE_OFS_CTRL_PERMIT, 32'h3ff);
    rdc(`SAGE_OFS_UPD_EN, 0);
    rdc(`SAGE_OFS_CORR_EN, 0);
    bus(1, `SAGE_OFS_DMA_PERMIT, 0);
    rdc(`SAGE_OFS_DMA_PERMIT, 32'h3ff);
    bus(0, 12'hffc, 0);
    cmp(e, 1);
    fire(4'hf, 1);
    rdc(`SAGE_OFS_CNT0, 0);
    bus(1, `SAGE_OFS_CORR_EN, 32'hffffffff);
    rdc(`SAGE_OFS_CORR_EN, 3);
    cmp({30'h0, sram_correct_enable_o}, 3);
    fire(4'hf, 1);
    rdc(`SAGE_OFS_FLAGS, 0);
    bus(1, `SAGE_OFS_UPD_EN, 32'hffffffff);
    rdc(`SAGE_OFS_UPD_EN, 32'hf);
    for (int i = 0; i < 4; i++) begin
      fire(4'h1 << i, 1);
      rdc(`SAGE_OFS_FLAGS, (32'h2 << i) - 1);
    end
    rdc(`SAGE_OFS_ADR0, {6'h0, ea[12:0], ea[12:0]});
    rdc(`SAGE_OFS_ADR1, {6'h0, ea[25:13], ea[25:13]});
    bus(1, `SAGE_OFS_FLAGS, 32'h5);
    rdc(`SAGE_OFS_FLAGS, 32'ha);
    for (int i = 0; i < 4; i++) begin
      bus(1, `SAGE_OFS_CNT_CLR, 32'h1 << i);
      rdc(i < 2 ? `SAGE_OFS_CNT0 : `SAGE_OFS_CNT1, i % 2 ? 0 : 32'h20000);
    end
    rdc(`SAGE_OFS_CNT_CLR, 0);
    fire(4'h1, 65537);
    rdc(`SAGE_OFS_CNT0, 32'hffff);
    cfg_dma_permits_i <= 10'h155;
    cfg_ctrl_permits_i <= 10'h2aa;
    cfg_load_i <= 1;
    @(posedge clk_i);
    cfg_load_i <= 0;
    @(posedge clk_i);
    rdc(`SAGE_OFS_CTRL_PERMIT, 32'h2aa);
    for (int k = 0; k < 30; k++) begin
      p = ms[k / 10] == 9 ? 10'h2aa : 10'h155;
      chk_master_i <= 4'(ms[k / 10]);
      chk_slave_i <= 3'(ss[(k / 2) % 5]);
      chk_write_i <= k[0];
      chk_valid_i <= 1;
      @(posedge clk_i);
      chk_valid_i <= 0;
      @(posedge clk_i);
      cmp({chk_done_o, chk_err_o}, {1'b1, ~p[(ss[(k / 2) % 5] % 6 + (ss[(k / 2) % 5] == 6 ? 4 : 0)) * 2 + k[0]]});
    end
    report_and_stop;
  end
endmodule // testbench
